// ---- design/fvcb_consts.svh ----
// constants of the fault value capture bank: register map, field layout, codes
// assumes byte addressing on a 32-bit apb bus, one register per aligned word
//
// Behaviour
// - up to twelve channels, each holds the value present when its stage starts or trips.
// - captured values readable by local readout and by the protocol path when active.
// - source per channel: overcurrent, directional overcurrent, earth fault stages, locator, or unused.
// - trigger per channel: trip only, start only, or either signal.
// - held value is the measurement at the trigger instant, in hundredths of a unit.
`ifndef FVCB_CONSTS_SVH
`define FVCB_CONSTS_SVH

`define FVCB_NCH 12
`define FVCB_NSTAGE 16
`define FVCB_VW 32

// source codes; each stage family has four stages, indexed code minus one
`define FVCB_SRC_UNUSED 5'h00
`define FVCB_SRC_OC_FIRST 5'h01
`define FVCB_SRC_EF_FIRST 5'h09
`define FVCB_SRC_STAGE_LAST 5'h10
`define FVCB_SRC_LOCATOR 5'h11
`define FVCB_SRC_ONE 5'h01

// trigger codes; trip only is the reset choice, code 3 behaves as trip only
`define FVCB_TRG_TRIP 2'h0
`define FVCB_TRG_START 2'h1
`define FVCB_TRG_EITHER 2'h2

// register byte offsets
`define FVCB_OFF_CFG 8'h00
`define FVCB_OFF_VAL 8'h40
`define FVCB_OFF_STATUS 8'h80
`define FVCB_OFF_MASK 8'h84
`define FVCB_OFF_CTRL 8'h88
`define FVCB_OFF_BLOCK 8'h30

// field positions in the channel setting word
`define FVCB_CFG_SRC_LSB 0
`define FVCB_CFG_SRC_MSB 4
`define FVCB_CFG_TRG_LSB 8
`define FVCB_CFG_TRG_MSB 9
`define FVCB_CTRL_PROTO_BIT 0

`endif

// ---- design/fvcb_pkg.sv ----
// types of the fault value capture bank
// assumes fvcb_consts.svh on the include path
`include "fvcb_consts.svh"

package fvcb_pkg;

	// signed value in hundredths of a unit
	typedef logic signed [`FVCB_VW-1:0] fvcb_val_t;

	typedef struct packed
	{
		logic [1:0] trg;
		logic [4:0] src;
	} fvcb_cfg_t;

	typedef struct packed
	{
		logic [`FVCB_NSTAGE-1:0] start;
		logic [`FVCB_NSTAGE-1:0] trip;
		logic loc_start;
		logic loc_trip;
	} fvcb_stage_t;

	typedef struct packed
	{
		fvcb_val_t phase;
		fvcb_val_t resid;
		fvcb_val_t loc;
	} fvcb_meas_t;

	typedef struct packed
	{
		fvcb_val_t value;
	} fvcb_chan_st_t;

	typedef struct packed
	{
		fvcb_cfg_t [`FVCB_NCH-1:0] cfg;
		logic [`FVCB_NCH-1:0] status;
		logic [`FVCB_NCH-1:0] mask;
		logic proto_en;
		fvcb_stage_t prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		fvcb_val_t local_value;
		logic local_valid;
	} fvcb_top_st_t;

endpackage

// ---- design/fvcb_channel.sv ----
// one capture channel: picks its source stage and trigger, latches the measurement
// assumes rising edges of start and trip arrive as one-cycle pulses on the same clock
`timescale 1ns/1ps

module fvcb_channel
	import fvcb_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset
	input wire fvcb_cfg_t cfg, // source and trigger choice
	input wire fvcb_stage_t rise, // rising edges of stage signals
	input wire fvcb_meas_t meas, // live measurements
	output fvcb_val_t value, // held value
	output logic capture // pulse, capture this cycle
);

	fvcb_chan_st_t st;
	fvcb_chan_st_t next_st;
	logic [4:0] idx;
	logic sel_start;
	logic sel_trip;
	fvcb_val_t sel_meas;

	assign idx = cfg.src - `FVCB_SRC_ONE;

	always_comb
	begin
		sel_start = 1'b0;
		sel_trip = 1'b0;
		sel_meas = meas.phase;
		if (cfg.src >= `FVCB_SRC_OC_FIRST && cfg.src <= `FVCB_SRC_STAGE_LAST)
		begin
			sel_start = rise.start[idx[3:0]];
			sel_trip = rise.trip[idx[3:0]];
			// phase families read phase current, earth families the residual current
			sel_meas = (cfg.src < `FVCB_SRC_EF_FIRST) ? meas.phase : meas.resid;
		end
		else if (cfg.src == `FVCB_SRC_LOCATOR)
		begin
			sel_start = rise.loc_start;
			sel_trip = rise.loc_trip;
			sel_meas = meas.loc;
		end
		// unused and undefined codes leave both selects low, so nothing captures
		if (cfg.trg == `FVCB_TRG_START)
			capture = sel_start;
		else if (cfg.trg == `FVCB_TRG_EITHER)
			capture = sel_start | sel_trip;
		else
			capture = sel_trip;
		next_st = st;
		if (capture)
			next_st.value = sel_meas;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign value = st.value;

	a_unused_hold: assert property (@(posedge clk) disable iff (!rst_b)
		cfg.src == `FVCB_SRC_UNUSED |=> $stable(value))
		else $error("unused channel changed its value");

	a_capture_value: assert property (@(posedge clk) disable iff (!rst_b)
		capture |=> value == $past(sel_meas))
		else $error("captured value differs from measurement at trigger");

	a_trip_only: assert property (@(posedge clk) disable iff (!rst_b)
		(cfg.trg == `FVCB_TRG_TRIP && !sel_trip) |=> $stable(value))
		else $error("trip-only channel captured without a trip edge");

	a_locator_src: assert property (@(posedge clk) disable iff (!rst_b)
		(cfg.src == `FVCB_SRC_LOCATOR && cfg.trg == `FVCB_TRG_EITHER && rise.loc_start)
		|=> value == $past(meas.loc))
		else $error("locator channel did not take the locator value");

endmodule // fvcb_channel

// ---- design/fvcb_top.sv ----
// fault value capture bank: twelve channels behind an apb register slave
// assumes stage start and trip levels and measurements come from logic on clk
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps

module fvcb_top
	import fvcb_pkg::*;
(
	input wire logic clk, // 20 MHz system clock
	input wire logic rst_b, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire fvcb_stage_t stage_in, // stage start and trip levels
	input wire fvcb_meas_t meas_in, // live measurements, hundredths
	input wire logic [3:0] local_idx, // local readout channel index
	output fvcb_val_t local_value, // local readout value
	output logic local_valid, // local index names a channel
	output logic irq // level, unmasked capture pending
);

	fvcb_top_st_t st;
	fvcb_top_st_t next_st;
	fvcb_stage_t rise;
	fvcb_val_t chan_val [`FVCB_NCH];
	logic [`FVCB_NCH-1:0] chan_cap;
	logic [`FVCB_NCH-1:0] clr;
	logic [`FVCB_NCH-1:0] wr_bit;
	logic access;
	logic do_write;
	logic aligned;
	logic is_cfg;
	logic is_val;
	logic is_stat;
	logic is_mask;
	logic is_ctrl;
	logic mapped;
	logic [3:0] widx;
	logic [7:0] rel_val;
	fvcb_val_t val_sel;
	fvcb_val_t local_sel;

	// edges are taken against last cycle, so a level held high captures once
	assign rise = stage_in & ~st.prev;

	for (genvar i = 0; i < `FVCB_NCH; i++)
	begin : g_chan
		fvcb_channel u_chan
		(
			.clk(clk),
			.rst_b(rst_b),
			.cfg(st.cfg[i]),
			.rise(rise),
			.meas(meas_in),
			.value(chan_val[i]),
			.capture(chan_cap[i])
		);
	end

	assign access = psel & penable;
	assign aligned = (paddr[1:0] == 2'h0);
	assign rel_val = paddr - `FVCB_OFF_VAL;
	always_comb
	begin
		is_cfg = 1'b0;
		is_val = 1'b0;
		is_stat = 1'b0;
		is_mask = 1'b0;
		is_ctrl = 1'b0;
		widx = 4'h0;
		if (!aligned)
			widx = 4'h0;
		else if (paddr >= `FVCB_OFF_CFG && paddr < `FVCB_OFF_CFG + `FVCB_OFF_BLOCK)
		begin
			is_cfg = 1'b1;
			widx = paddr[5:2];
		end
		else if (paddr >= `FVCB_OFF_VAL && paddr < `FVCB_OFF_VAL + `FVCB_OFF_BLOCK)
		begin
			is_val = 1'b1;
			widx = rel_val[5:2];
		end
		else if (paddr == `FVCB_OFF_STATUS)
			is_stat = 1'b1;
		else if (paddr == `FVCB_OFF_MASK)
			is_mask = 1'b1;
		else if (paddr == `FVCB_OFF_CTRL)
			is_ctrl = 1'b1;
	end
	assign mapped = is_cfg | is_val | is_stat | is_mask | is_ctrl;
	assign val_sel = chan_val[widx];
	assign local_sel = (local_idx < `FVCB_NCH) ? chan_val[local_idx] : '0;

	// a write takes effect at the edge where the master samples pready high
	assign do_write = access & st.pready & pwrite & mapped;
	assign wr_bit = pwdata[`FVCB_NCH-1:0];
	assign clr = (do_write && is_stat) ? wr_bit : '0;

	always_comb
	begin
		next_st = st;
		next_st.prev = stage_in;
		// one wait state: pready rises in the second access cycle
		next_st.pready = access & ~st.pready;
		if (access && !st.pready)
		begin
			next_st.prdata = '0;
			next_st.pslverr = ~mapped;
			if (!pwrite)
			begin
				if (is_cfg)
				begin
					next_st.prdata[`FVCB_CFG_SRC_MSB:`FVCB_CFG_SRC_LSB] = st.cfg[widx].src;
					next_st.prdata[`FVCB_CFG_TRG_MSB:`FVCB_CFG_TRG_LSB] = st.cfg[widx].trg;
				end
				else if (is_val)
				begin
					// the protocol path shows values only while the protocol is active
					if (st.proto_en)
						next_st.prdata = val_sel;
				end
				else if (is_stat)
					next_st.prdata[`FVCB_NCH-1:0] = st.status;
				else if (is_mask)
					next_st.prdata[`FVCB_NCH-1:0] = st.mask;
				else if (is_ctrl)
					next_st.prdata[`FVCB_CTRL_PROTO_BIT] = st.proto_en;
			end
		end
		else if (!access)
		begin
			next_st.pslverr = 1'b0;
		end
		if (do_write)
		begin
			if (is_cfg)
			begin
				next_st.cfg[widx].src = pwdata[`FVCB_CFG_SRC_MSB:`FVCB_CFG_SRC_LSB];
				next_st.cfg[widx].trg = pwdata[`FVCB_CFG_TRG_MSB:`FVCB_CFG_TRG_LSB];
			end
			else if (is_mask)
				next_st.mask = wr_bit;
			else if (is_ctrl)
				next_st.proto_en = pwdata[`FVCB_CTRL_PROTO_BIT];
		end
		// a capture in the cycle of a clearing write stays set
		next_st.status = (st.status & ~clr) | chan_cap;
		next_st.irq = |(next_st.status & next_st.mask);
		// local readout runs regardless of the protocol switch
		next_st.local_value = local_sel;
		next_st.local_valid = (local_idx < `FVCB_NCH);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign local_value = st.local_value;
	assign local_valid = st.local_valid;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_value_read: assert property (
		(access && !st.pready && !pwrite && is_val && st.proto_en)
		|=> pready && prdata == $past(val_sel))
		else $error("protocol read of a value returned wrong data");

	a_proto_off: assert property (
		(access && !st.pready && !pwrite && is_val && !st.proto_en) |=> prdata == 32'h0)
		else $error("value visible while protocol inactive");

	a_local_path: assert property (
		(local_idx < `FVCB_NCH) |=> local_valid && local_value == $past(local_sel))
		else $error("local readout mismatch");

	a_status_set: assert property (
		(chan_cap != '0) |=> (st.status & $past(chan_cap)) == $past(chan_cap))
		else $error("capture did not set its status bit");

	a_irq_follow: assert property (
		((chan_cap & st.mask) != '0 && !do_write) |=> irq ##1 (irq || $past(do_write)))
		else $error("unmasked capture did not raise the interrupt");

	a_err_unmapped: assert property (
		(access && !st.pready && !mapped) |=> pready && pslverr)
		else $error("unmapped access not flagged");

	// bus handshake: exactly one wait state, the answer lasts one cycle
	a_ready_once: assert property (
		(access && !st.pready) |=> pready)
		else $error("access not answered after one wait state");

	a_ready_single: assert property (
		pready |=> !pready)
		else $error("ready held for more than one cycle");

	a_ready_idle: assert property (
		!access |=> !pready)
		else $error("ready raised without an access");

	a_err_mapped: assert property (
		(access && !st.pready && mapped) |=> !pslverr)
		else $error("error flagged on a mapped register");

	a_err_clear: assert property (
		!access |=> !pslverr)
		else $error("error flag left standing after the access");

	a_err_zero: assert property (
		(access && !st.pready && !mapped) |=> prdata == 32'h0)
		else $error("unmapped access returned data");

	a_prdata_hold: assert property (
		!(access && !st.pready) |=> $stable(prdata))
		else $error("read data changed outside a decode cycle");

	// register read-back and write effects
	a_status_read: assert property (
		(access && !st.pready && !pwrite && is_stat) |=> prdata[`FVCB_NCH-1:0] == $past(st.status) && prdata[31:`FVCB_NCH] == '0)
		else $error("status read-back wrong");

	a_mask_read: assert property (
		(access && !st.pready && !pwrite && is_mask) |=> prdata[`FVCB_NCH-1:0] == $past(st.mask) && prdata[31:`FVCB_NCH] == '0)
		else $error("mask read-back wrong");

	a_ctrl_read: assert property (
		(access && !st.pready && !pwrite && is_ctrl) |=> prdata == {31'h0, $past(st.proto_en)})
		else $error("control read-back wrong");

	a_cfg_read: assert property (
		(access && !st.pready && !pwrite && is_cfg) |=> prdata[`FVCB_CFG_SRC_MSB:`FVCB_CFG_SRC_LSB] == $past(st.cfg[widx].src)
		&& prdata[`FVCB_CFG_TRG_MSB:`FVCB_CFG_TRG_LSB] == $past(st.cfg[widx].trg))
		else $error("channel setting read-back wrong");

	a_cfg_write: assert property (
		(do_write && is_cfg) |=> st.cfg[$past(widx)].src == $past(pwdata[`FVCB_CFG_SRC_MSB:`FVCB_CFG_SRC_LSB]))
		else $error("source choice not written");

	a_trg_write: assert property (
		(do_write && is_cfg) |=> st.cfg[$past(widx)].trg == $past(pwdata[`FVCB_CFG_TRG_MSB:`FVCB_CFG_TRG_LSB]))
		else $error("trigger choice not written");

	a_mask_write: assert property (
		(do_write && is_mask) |=> st.mask == $past(wr_bit))
		else $error("mask not written");

	a_ctrl_write: assert property (
		(do_write && is_ctrl) |=> st.proto_en == $past(pwdata[`FVCB_CTRL_PROTO_BIT]))
		else $error("protocol switch not written");

	a_no_bad_write: assert property (
		(access && st.pready && pwrite && !mapped) |=> $stable(st.cfg) && $stable(st.mask) && $stable(st.proto_en))
		else $error("refused write changed a setting");

	// sticky status and interrupt
	a_w1c_clear: assert property (
		(do_write && is_stat && chan_cap == '0) |=> (st.status & $past(wr_bit)) == '0)
		else $error("write of one did not clear status");

	a_status_hold: assert property (
		(!do_write && chan_cap == '0) |=> $stable(st.status))
		else $error("status changed with no capture and no write");

	a_irq_quiet: assert property (
		((st.status & st.mask) == '0 && chan_cap == '0 && !do_write) |=> !irq)
		else $error("interrupt raised with nothing pending");

	a_irq_mask: assert property (
		(do_write && is_mask && (st.status & wr_bit) != '0) |=> irq)
		else $error("unmasking a set status bit did not raise the interrupt");

	// local readout
	a_local_none: assert property (
		(local_idx >= `FVCB_NCH) |=> !local_valid && local_value == '0)
		else $error("local readout shown for a missing channel");

	// per-channel checks on the capture pulses
	for (genvar j = 0; j < `FVCB_NCH; j++)
	begin : g_chk
		a_unused_quiet: assert property (@(posedge clk) disable iff (!rst_b)
			st.cfg[j].src == `FVCB_SRC_UNUSED |-> !chan_cap[j])
			else $error("unused channel raised a capture");

		a_cap_edge: assert property (@(posedge clk) disable iff (!rst_b)
			chan_cap[j] |-> rise != '0)
			else $error("capture without a stage edge");

		a_cap_status: assert property (@(posedge clk) disable iff (!rst_b)
			chan_cap[j] |=> st.status[j])
			else $error("capture did not mark its channel");
	end

endmodule // fvcb_top

// ---- verification/fvcb_stage_model.sv ----
// partner model: protection stage logic driving start/trip levels and measurements
// assumes the bench raises fire just after a rising edge of clk
`timescale 1ns/1ps

module fvcb_stage_model
	import fvcb_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic fire, // raise chosen signals for one cycle
	input wire logic [4:0] code, // source code
	input wire logic [1:0] kind, // bit0 start, bit1 trip
	input wire fvcb_val_t base, // value shown while a signal is up
	output fvcb_stage_t stage, // stage levels
	output fvcb_meas_t meas // live measurements
);
	logic up;
	assign up = |stage;
	// inverted away from the event, so an early or late capture shows
	assign meas = up ? {base, base + 1, base + 2} : ~{base, base + 1, base + 2};
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			stage <= '0;
		else
		begin
			stage <= '0;
			if (fire && code == 5'h11)
			begin
				stage.loc_start <= kind[0];
				stage.loc_trip <= kind[1];
			end
			else if (fire && code != 5'h00)
			begin
				stage.start[code - 5'h01] <= kind[0];
				stage.trip[code - 5'h01] <= kind[1];
			end
		end
	end
endmodule // fvcb_stage_model

// ---- verification/fvcb_bench.sv ----
// testbench of the capture bank: apb master, stage model, row table then hand tests
// assumes the design answers apb with one wait state and needs no parameters
`timescale 1ns/1ps

module fault_value_capture_bank_bench
	import fvcb_pkg::*;
;
	typedef struct {logic [4:0] src; logic [1:0] trg; logic [1:0] kind; logic hit;} fvcb_row_t;
	logic clk, rst_b, psel, penable, pwrite, pready, pslverr, local_valid, irq, fire, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] local_idx;
	logic [4:0] code;
	logic [1:0] kind;
	fvcb_val_t base, local_value;
	fvcb_stage_t stage;
	fvcb_meas_t meas;
	int bad_count, n_compared;
	fvcb_row_t rows [8] = '{'{5'h01, 2'h0, 2'h2, 1'b1}, '{5'h05, 2'h1, 2'h1, 1'b1},
		'{5'h09, 2'h2, 2'h2, 1'b1}, '{5'h0d, 2'h2, 2'h1, 1'b1}, '{5'h10, 2'h3, 2'h1, 1'b0},
		'{5'h11, 2'h1, 2'h1, 1'b1}, '{5'h04, 2'h1, 2'h2, 1'b0}, '{5'h11, 2'h0, 2'h2, 1'b1}};

	fvcb_top u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.stage_in(stage), .meas_in(meas), .local_idx(local_idx), .local_value(local_value),
		.local_valid(local_valid), .irq(irq));
	fvcb_stage_model u_far (.clk(clk), .rst_b(rst_b), .fire(fire), .code(code), .kind(kind),
		.base(base), .stage(stage), .meas(meas));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse(input logic [4:0] c, input logic [1:0] k, input logic [31:0] b);
		@(posedge clk);
		fire <= 1'b1;
		code <= c;
		kind <= k;
		base <= b;
		@(posedge clk);
		fire <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] exp_val(input int i);
		if (!rows[i].hit)
			return 32'h0;
		return 32'(i * 1000 - 3000) + (rows[i].src == 5'h11 ? 32'h2 : rows[i].src > 5'h08 ? 32'h1 : 32'h0);
	endfunction

	task automatic report_and_stop;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		repeat (4000) @(posedge clk);
		bad_count++;
		report_and_stop;
	end

	initial
	begin
		{rst_b, psel, penable, pwrite, fire, paddr, pwdata, code, kind, base, local_idx} = '0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, 8'h88, 32'h1);
		apb(1'b0, 8'h88, 32'h0);
		chk(q, 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, 8'(4 * i), {22'h0, rows[i].trg, 3'h0, rows[i].src});
			pulse(rows[i].src, rows[i].kind, 32'(i * 1000 - 3000));
			apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
			chk(q, exp_val(i));
		end
		apb(1'b0, 8'h80, 32'h0);
		chk(q, 32'h0af);
		$display("row table done");
		apb(1'b1, 8'h84, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, 8'h84, 32'h0);
		chk(q, 32'h1);
		apb(1'b1, 8'h80, 32'h1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("interrupt done");
		pulse(5'h01, 2'h2, 32'h22b);
		apb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h22b);
		apb(1'b0, 8'h60, 32'h0);
		chk(q, 32'h0);
		$display("unused channel done");
		local_idx <= 4'h0;
		repeat (2) @(posedge clk);
		chk(local_value, 32'h22b);
		apb(1'b1, 8'h88, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		local_idx <= 4'hc;
		repeat (2) @(posedge clk);
		chk({31'h0, local_valid}, 32'h0);
		apb(1'b1, 8'h8c, 32'h1);
		chk({q[30:0], e}, 32'h1);
		$display("readout and errors done");
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, 8'h80, 32'h0);
		chk(q, 32'h0);
		$display("mid-run reset done");
		report_and_stop;
	end
endmodule // fault_value_capture_bank_bench
